// ==== hw/scm_pkg.sv ====
package scm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame lengths and key.
  localparam logic [15:0] KEY_VALUE = 16'h5a5a;
  localparam logic [4:0] KEY_LEN = 5'h10;
  localparam logic [4:0] CMD_LEN = 5'h0e;
  localparam logic [4:0] RX_MAX_LEN = 5'h10;

  // Command frame fields, as seen after alignment.
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_RW_BIT = 12;

  // Register addresses.
  localparam logic [3:0] ADDR_USER = 4'h0;
  localparam logic [3:0] ADDR_CFG_TWO = 4'h3;
  localparam logic [3:0] ADDR_RAM_END = 4'h3;
  localparam logic [3:0] ADDR_EXIT = 4'ha;
  localparam logic [3:0] ADDR_SERIAL = 4'hb;
  localparam logic [3:0] ADDR_MFG = 4'hf;
  localparam logic [7:0] EXIT_VALUE = 8'h80;
  localparam logic [7:0] RAM_RESET = 8'h00;
  localparam logic [7:0] MFG_ID_DEF = 8'h3c; // Arbitrary value.

  // Bit positions inside the working registers.
  localparam int LOCK_BIT = 7;
  localparam int MON_BIT = 5;
  localparam int SYNC_EN_BIT = 5;
  localparam int FUSE_LOCK_POS = 31;

  // Transmit frame.
  localparam logic [2:0] SV_OK = 3'h5;
  localparam logic [2:0] SV_ERR = 3'h6;
  localparam logic [1:0] START_BITS = 2'h1;
  localparam logic [4:0] TX_LAST_BIT = 5'h11;

  // Timing at the 100 MHz system clock.
  localparam int SYS_MHZ = 100;
  localparam int INIT_TIME_US = 1000;
  localparam int INIT_CYC = INIT_TIME_US * SYS_MHZ;
  localparam int TX_HALF_NS = 4000;
  localparam int TX_HALF_CYC = (TX_HALF_NS * SYS_MHZ) / 1000;

  // Supply-line symbol thresholds in link clock cycles.
  localparam logic [7:0] RX_ZERO_MAX = 8'h08;
  localparam logic [7:0] RX_ONE_MAX = 8'h10;
  localparam logic [7:0] RX_CLOCK_MAX = 8'h28;

  typedef enum logic [4:0] {
    ST_INIT = 5'b00001,
    ST_CFG = 5'b00010,
    ST_ACK = 5'b00100,
    ST_TX = 5'b01000,
    ST_RUN = 5'b10000
  } scm_state_t;

endpackage : scm_pkg

// ==== hw/scm_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module scm_sync #(
  parameter int W = 1
) (
  // Clock.
  input wire logic clk_in,
  // Level from another domain and its safe copy.
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;

  // Two stages; only the second stage reads the first.
  always_ff @(posedge clk_in) begin
    meta_q <= d_in;
    q_out <= meta_q;
  end
endmodule : scm_sync
`default_nettype wire

// ==== hw/scm_pdm_rx.sv ====
`timescale 1ns/100ps
`default_nettype none
module scm_pdm_rx #(
  parameter logic [7:0] ZERO_MAX = scm_pkg::RX_ZERO_MAX,
  parameter logic [7:0] ONE_MAX = scm_pkg::RX_ONE_MAX,
  parameter logic [7:0] CLOCK_MAX = scm_pkg::RX_CLOCK_MAX
) (
  // Link clock and its reset.
  input wire logic clk_link_in,
  input wire logic rst_link_in,
  // Synchronised supply-line level.
  input wire logic level_in,
  // Completed frame, held until the next toggle.
  output logic [15:0] word_out,
  output logic [4:0] len_out,
  output logic toggle_out
);
  import scm_pkg::*;

  logic lvl_q;
  logic [7:0] hi_q;
  logic [7:0] lo_q;
  logic [15:0] sh_q;
  logic [4:0] n_q;
  logic bad_q;

  // The high time of a pulse carries the bit, the low time the clock.
  wire fall = lvl_q & ~level_in;
  wire is_zero = hi_q <= ZERO_MAX;
  wire is_one = !is_zero && (hi_q <= ONE_MAX);
  wire gap = !level_in && (lo_q == CLOCK_MAX - 8'h01);
  wire frame_end = gap && (n_q != 5'h00);
  wire frame_good = !bad_q && (n_q <= RX_MAX_LEN);

  // Pulse width counters saturate so a stuck line cannot wrap.
  always_ff @(posedge clk_link_in) begin
    if (rst_link_in) begin
      lvl_q <= 1'b0;
      hi_q <= 8'h00;
      lo_q <= 8'h00;
    end else begin
      lvl_q <= level_in;
      hi_q <= !level_in ? 8'h00 : hi_q + {7'h00, hi_q != 8'hff};
      lo_q <= level_in ? 8'h00 : lo_q + {7'h00, lo_q != CLOCK_MAX};
    end
  end

  // Bits shift in from the top, so the first bit ends lowest.
  always_ff @(posedge clk_link_in) begin
    if (rst_link_in) begin
      sh_q <= 16'h0000;
      n_q <= 5'h00;
      bad_q <= 1'b0;
    end else if (frame_end) begin
      n_q <= 5'h00;
      bad_q <= 1'b0;
    end else if (fall) begin
      sh_q <= {is_one, sh_q[15:1]};
      n_q <= n_q + {4'h0, n_q != 5'h1f};
      bad_q <= bad_q | !(is_zero | is_one);
    end
  end

  // A frame is offered once; the word stays put while the toggle crosses.
  always_ff @(posedge clk_link_in) begin
    if (rst_link_in) begin
      word_out <= 16'h0000;
      len_out <= 5'h00;
      toggle_out <= 1'b0;
    end else if (frame_end && frame_good) begin
      word_out <= sh_q;
      len_out <= n_q;
      toggle_out <= ~toggle_out;
    end
  end
endmodule : scm_pdm_rx
`default_nettype wire

// ==== hw/scm_config_port.sv ====
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Key during initialization enters configuration mode.
// - Sixteen bits is key, fourteen is command.
// - Inbound symbols are pulse widths on supply.
// - Entry reply carries config register two.
// - Late pulses are sync pulses or ignored.
// - Reply protocol is fixed in configuration mode.
// - Reply: start 10b, 101b, data, address, parity.
// - Reply parity is bit fifteen, sent last.
// - Direction zero writes, one reads.
// - Every command gets exactly one reply.
// - Bad parity replies 110b with zeros.
// - Unlocked write stores, reads back, replies.
// - Locked write is dropped, fuse byte replied.
// - Read replies working register, data ignored.
// - Locked fuses load into working registers.
// - Writing 0x80 at 1010b restarts initialization.
// - Serial number and maker id are readable.
// - Monitor pin enable defaults off.
module scm_config_port #(
  parameter int INIT_CYCLES = scm_pkg::INIT_CYC,
  parameter int TX_HALF = scm_pkg::TX_HALF_CYC,
  // Arbitrary maker code.
  parameter logic [7:0] MFG_ID = scm_pkg::MFG_ID_DEF
) (
  // System clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Link sampling clock.
  input wire logic clk_link_in,
  // Supply-line comparator levels.
  input wire logic positive_bus_pin_in,
  input wire logic negative_bus_pin_in,
  // Fuse array image and serial number.
  input wire logic [31:0] fuse_image_in,
  input wire logic [31:0] serial_number_in,
  // Current-mode port.
  output logic current_loop_out,
  // Mode and status.
  output logic cfg_mode_out,
  output logic sync_pulse_out,
  output logic restart_out,
  output logic analog_monitor_output_enable_out,
  output logic [31:0] working_regs_out
);
  import scm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Link side.

  logic [1:0] pins_s;
  logic rst_link_s;
  logic [15:0] rx_word;
  logic [4:0] rx_len;
  logic rx_tgl;
  logic tgl_s;
  logic tgl_d_q;

  scm_sync #(.W(2)) u_pin_sync (
    .clk_in(clk_link_in),
    .d_in({positive_bus_pin_in, negative_bus_pin_in}),
    .q_out(pins_s)
  );

  scm_sync #(.W(1)) u_rst_sync (
    .clk_in(clk_link_in),
    .d_in(rst_in),
    .q_out(rst_link_s)
  );

  // The positive pin counts only when it stands above the negative one.
  wire bus_level = pins_s[1] & ~pins_s[0];

  scm_pdm_rx u_rx (
    .clk_link_in(clk_link_in),
    .rst_link_in(rst_link_s),
    .level_in(bus_level),
    .word_out(rx_word),
    .len_out(rx_len),
    .toggle_out(rx_tgl)
  );

  // The word is stable for a whole frame time after the toggle moves.
  scm_sync #(.W(1)) u_tgl_sync (
    .clk_in(clk_sys_in),
    .d_in(rx_tgl),
    .q_out(tgl_s)
  );

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      tgl_d_q <= 1'b0;
    end else begin
      tgl_d_q <= tgl_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame decode.

  scm_state_t st_q;
  scm_state_t st_d;
  logic [7:0] ram_q [4];
  logic [31:0] init_cnt_q;
  logic [3:0] a_q;
  logic perr_q;
  logic lkw_q;
  logic ext_q;
  logic [17:0] tx_sh_q;
  logic [15:0] half_q;
  logic ph_q;
  logic [4:0] bit_q;

  wire rx_new = tgl_s ^ tgl_d_q;
  wire key_ok = rx_new && (rx_len == KEY_LEN) && (rx_word == KEY_VALUE);
  wire cmd_ok = rx_new && (rx_len == CMD_LEN);
  wire [13:0] cmd = rx_word[15:2];
  wire [7:0] c_data = cmd[CMD_DATA_LSB+:8];
  wire [3:0] c_addr = cmd[CMD_ADDR_LSB+:4];
  wire c_rd = cmd[CMD_RW_BIT];
  wire par_bad = ^cmd;
  wire is_wr = !par_bad && !c_rd;
  wire locked = fuse_image_in[FUSE_LOCK_POS];
  wire in_ram = c_addr <= ADDR_RAM_END;
  wire ram_wr = (st_q == ST_CFG) && cmd_ok && is_wr && !locked && in_ram;
  wire exit_hit = is_wr && (c_addr == ADDR_EXIT) && (c_data == EXIT_VALUE);
  wire init_end = init_cnt_q == 32'(INIT_CYCLES - 1);
  wire fuse_load = (st_q == ST_INIT) && (init_cnt_q == 32'h0) && locked;
  wire [31:0] ram_flat = {ram_q[3], ram_q[2], ram_q[1], ram_q[0]};
  wire mon_en = ram_q[3][MON_BIT];
  wire sync_en = ram_q[2][SYNC_EN_BIT];
  // Transmit bit timing; declared here because the sequencer reads it.
  wire half_end = half_q == 16'(TX_HALF - 1);
  wire tx_done = (st_q == ST_TX) && half_end && ph_q && (bit_q == TX_LAST_BIT);

  ////////////////////////////////////////////////////////////////////////////
  // Reply word.

  // Reads of addresses 0 to 3 come from the working registers, never the fuses.
  wire [1:0] sn_idx = a_q[1:0] + 2'h1;
  wire [4:0] sn_lsb = {sn_idx, 3'h0};
  wire [7:0] sn_byte = serial_number_in[sn_lsb+:8];
  wire [7:0] rd_val = (a_q <= ADDR_RAM_END) ? ram_q[a_q[1:0]] :
                      (a_q == ADDR_MFG) ? MFG_ID :
                      (a_q >= ADDR_SERIAL) ? sn_byte : 8'h00;
  wire [4:0] fuse_lsb = {a_q[1:0], 3'h0};
  wire [7:0] fuse_byte = fuse_image_in[fuse_lsb+:8];
  wire lk_src = lkw_q && (a_q <= ADDR_RAM_END);
  wire [7:0] ack_data = perr_q ? 8'h00 : (lk_src ? fuse_byte : rd_val);
  wire [3:0] ack_addr = perr_q ? 4'h0 : a_q;
  wire [2:0] ack_sv = perr_q ? SV_ERR : SV_OK;
  wire [14:0] ack_body = {ack_addr, ack_data, ack_sv};
  wire [15:0] ack_word = {^ack_body, ack_body};

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  // A frame arriving while a reply is on the wire is dropped; the far end
  // waits for the reply before it sends again.
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_INIT: begin
        if (key_ok) st_d = ST_ACK;
        else if (init_end) st_d = ST_RUN;
      end
      ST_CFG: begin
        if (cmd_ok) st_d = ST_ACK;
      end
      ST_ACK: st_d = ST_TX;
      ST_TX: begin
        if (tx_done) st_d = ext_q ? ST_INIT : ST_CFG;
      end
      ST_RUN: st_d = ST_RUN;
      default: st_d = ST_INIT;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_q <= ST_INIT;
    end else begin
      st_q <= st_d;
    end
  end

  // The phase-one window restarts from zero on every entry.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || st_q != ST_INIT) begin
      init_cnt_q <= 32'h0;
    end else if (!init_end) begin
      init_cnt_q <= init_cnt_q + 32'h1;
    end
  end

  // Capture what the reply needs while the command is still valid.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      a_q <= 4'h0;
      perr_q <= 1'b0;
      lkw_q <= 1'b0;
      ext_q <= 1'b0;
    end else if (st_q == ST_INIT && key_ok) begin
      a_q <= ADDR_CFG_TWO;
      perr_q <= 1'b0;
      lkw_q <= 1'b0;
      ext_q <= 1'b0;
    end else if (st_q == ST_CFG && cmd_ok) begin
      a_q <= c_addr;
      perr_q <= par_bad;
      lkw_q <= is_wr && locked;
      ext_q <= exit_hit;
    end
  end

  // Working registers; a restart keeps them, only reset clears them.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      for (int i = 0; i < 4; i++) ram_q[i] <= RAM_RESET;
    end else if (fuse_load) begin
      for (int i = 0; i < 4; i++) ram_q[i] <= fuse_image_in[8*i+:8];
    end else if (ram_wr) begin
      ram_q[c_addr[1:0]] <= c_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Manchester transmitter.

  // The frame is fixed whatever the working registers say.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      tx_sh_q <= 18'h0;
      half_q <= 16'h0;
      ph_q <= 1'b0;
      bit_q <= 5'h0;
    end else if (st_q == ST_ACK) begin
      tx_sh_q <= {ack_word, START_BITS};
      half_q <= 16'h0;
      ph_q <= 1'b0;
      bit_q <= 5'h0;
    end else if (st_q == ST_TX) begin
      half_q <= half_end ? 16'h0 : half_q + 16'h1;
      if (half_end) begin
        ph_q <= ~ph_q;
        if (ph_q) begin
          tx_sh_q <= {1'b0, tx_sh_q[17:1]};
          bit_q <= bit_q + 5'h1;
        end
      end
    end
  end

  // First half carries the bit, second half its complement.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      current_loop_out <= 1'b0;
    end else begin
      current_loop_out <= (st_q == ST_TX) && (tx_sh_q[0] ^ ph_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs.

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cfg_mode_out <= 1'b0;
      sync_pulse_out <= 1'b0;
      restart_out <= 1'b0;
      analog_monitor_output_enable_out <= 1'b0;
      working_regs_out <= 32'h0;
    end else begin
      cfg_mode_out <= st_d inside {ST_CFG, ST_ACK, ST_TX};
      sync_pulse_out <= (st_q == ST_RUN) && rx_new && sync_en;
      restart_out <= tx_done && ext_q;
      analog_monitor_output_enable_out <= mon_en;
      working_regs_out <= ram_flat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  sequence s_cmd_taken;
    st_q == ST_CFG && cmd_ok;
  endsequence

  sequence s_exit_done;
    st_q == ST_TX && ext_q && tx_done;
  endsequence

  a_key_entry: assert property (
    st_q == ST_INIT && key_ok |=> st_q == ST_ACK && a_q == ADDR_CFG_TWO && cfg_mode_out)
    else $error("Key did not start the entry reply.");

  a_late_key: assert property (
    st_q == ST_RUN |=> st_q == ST_RUN && !cfg_mode_out)
    else $error("Normal mode was left.");

  a_len_filter: assert property (
    st_q == ST_CFG && rx_new && rx_len != CMD_LEN |=> st_q == ST_CFG)
    else $error("A frame of wrong length was taken.");

  a_one_reply: assert property (
    s_cmd_taken |=> st_q == ST_ACK ##1 st_q == ST_TX)
    else $error("A command got no reply.");

  a_tx_frame: assert property (
    st_q == ST_ACK |=> tx_sh_q[1:0] == START_BITS && !(^tx_sh_q[17:2]))
    else $error("Reply frame start or parity is wrong.");

  a_perr_zero: assert property (
    st_q == ST_ACK && perr_q |=> tx_sh_q[17:2] == {13'h0, SV_ERR})
    else $error("Parity error reply is not zeroed.");

  a_wr_back: assert property (
    s_cmd_taken and ram_wr |=> ram_q[a_q[1:0]] == $past(c_data) ##2 tx_sh_q[12:5] == ram_q[a_q[1:0]])
    else $error("Write data was not stored and echoed.");

  a_lock_hold: assert property (
    st_q == ST_CFG && locked |=> $stable(ram_flat))
    else $error("Working registers changed while locked.");

  a_rd_value: assert property (
    st_q == ST_ACK && !perr_q && !lkw_q |=> tx_sh_q[12:5] == $past(rd_val))
    else $error("Read reply does not match the register.");

  a_fuse_load: assert property (
    fuse_load |=> ram_flat == $past(fuse_image_in))
    else $error("Fuse values were not loaded.");

  a_exit_restart: assert property (
    s_exit_done |=> st_q == ST_INIT && restart_out && init_cnt_q == 32'h0)
    else $error("Exit did not restart initialization.");

  a_mon_pin: assert property (
    ##1 analog_monitor_output_enable_out == $past(mon_en))
    else $error("Monitor enable does not follow its bit.");

endmodule : scm_config_port
`default_nettype wire

// ==== tb/scm_cfg_host.sv ====
`timescale 1ns/100ps
`default_nettype none
// Behavioural configuration system: pulse-width frames out, Manchester replies in.
module scm_cfg_host #(
  parameter int TX_HALF = 4
) (
  // Clocks.
  input wire logic clk_sys_in,
  input wire logic clk_link_in,
  // Supply-line drive.
  output logic positive_bus_pin_out,
  output logic negative_bus_pin_out,
  // Reply line.
  input wire logic current_loop_in
);
  ////////////////////////////////////////////////////////////////////////////
  // The line idles with both pins low.
  initial begin
    positive_bus_pin_out = 1'b0;
    negative_bus_pin_out = 1'b0;
  end

  // Between pulses both pins sit high, so only the difference reads low.
  task automatic send(input logic [15:0] word, input int len);
    repeat (45) @(posedge clk_link_in); // A long gap closes any earlier frame.
    for (int i = 0; i < len; i++) begin
      positive_bus_pin_out <= 1'b1;
      negative_bus_pin_out <= 1'b0;
      repeat (word[i] ? 12 : 4) @(posedge clk_link_in);
      negative_bus_pin_out <= 1'b1;
      repeat (4) @(posedge clk_link_in);
    end
    positive_bus_pin_out <= 1'b0;
    negative_bus_pin_out <= 1'b0;
  endtask : send

  ////////////////////////////////////////////////////////////////////////////
  // Finds the first half of the start bit, then samples each half mid-way.
  task automatic receive(output logic [17:0] bits, output logic ok);
    logic [35:0] half;
    int n;
    n = 0;
    ok = 1'b0;
    bits = '0;
    half = '0;
    while (current_loop_in !== 1'b1 && n < 4000) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    if (n < 4000) begin
      repeat (TX_HALF / 2) @(posedge clk_sys_in);
      for (int h = 0; h < 36; h++) begin
        #1;
        half[h] = current_loop_in;
        repeat (TX_HALF) @(posedge clk_sys_in);
      end
      ok = 1'b1;
      for (int k = 0; k < 18; k++) begin
        bits[k] = half[2*k];
        if (half[2*k+1] !== ~half[2*k]) ok = 1'b0;
      end
    end
  endtask : receive
endmodule : scm_cfg_host
`default_nettype wire

// ==== tb/tb_sensor_config_mode_port.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_sensor_config_mode_port;
  import scm_pkg::*;
  localparam int INIT_SIM = 2000;
  localparam logic [31:0] SN = 32'h1234abcd;
  localparam logic [7:0] MFG = 8'h96; // Arbitrary maker code.
  localparam logic [31:0] FUSE = 32'h80003311;
  logic clk_sys_in, clk_link_in, rst_in;
  logic [31:0] fuse_image_in, serial_number_in, working_regs_out;
  logic positive_bus_pin, negative_bus_pin, current_loop_out, cfg_mode_out;
  logic sync_pulse_out, restart_out, analog_monitor_output_enable_out;
  int err_count = 0;
  int compares = 0;
  int restart_cnt = 0;
  int sync_cnt = 0;

  ////////////////////////////////////////////////////////////////////////////
  // The link clock is left unrelated in phase to the system clock.
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    clk_link_in = 1'b0;
    #3;
    forever #6 clk_link_in = ~clk_link_in;
  end

  // Short windows keep the run brief.
  scm_config_port #(.INIT_CYCLES(INIT_SIM), .TX_HALF(4), .MFG_ID(MFG)) dut_u (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .clk_link_in(clk_link_in),
    .positive_bus_pin_in(positive_bus_pin), .negative_bus_pin_in(negative_bus_pin),
    .fuse_image_in(fuse_image_in), .serial_number_in(serial_number_in),
    .current_loop_out(current_loop_out), .cfg_mode_out(cfg_mode_out),
    .sync_pulse_out(sync_pulse_out), .restart_out(restart_out),
    .analog_monitor_output_enable_out(analog_monitor_output_enable_out),
    .working_regs_out(working_regs_out));

  scm_cfg_host #(.TX_HALF(4)) host_u (
    .clk_sys_in(clk_sys_in), .clk_link_in(clk_link_in),
    .positive_bus_pin_out(positive_bus_pin), .negative_bus_pin_out(negative_bus_pin),
    .current_loop_in(current_loop_out));

  // Single-cycle pulses are counted so that no check can miss one.
  always @(posedge clk_sys_in) begin
    if (restart_out === 1'b1) restart_cnt <= restart_cnt + 1;
    if (sync_pulse_out === 1'b1) sync_cnt <= sync_cnt + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared comparison, verdict and bus helpers.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic close_out();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out

  task automatic do_reset(input logic [31:0] fuse);
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    fuse_image_in <= fuse;
    repeat (4) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    #1;
  endtask : do_reset

  // Parity is worked out here so a bad frame is only ever sent on purpose.
  task automatic do_cmd(input logic rw, input logic [3:0] a, input logic [7:0] d, input logic bad);
    logic [12:0] body;
    body = {rw, a, d};
    host_u.send({2'b00, (^body) ^ bad, body}, 14);
  endtask : do_cmd

  task automatic expect_reply(input logic [3:0] a, input logic [7:0] d, input logic [2:0] sv);
    logic [17:0] f;
    logic ok;
    host_u.receive(f, ok);
    check("reply coding", 32'h1, {31'h0, ok});
    check("start bits", 32'h1, {30'h0, f[1:0]});
    check("state vector", {29'h0, sv}, {29'h0, f[4:2]});
    check("reply data", {24'h0, d}, {24'h0, f[12:5]});
    check("reply address", {28'h0, a}, {28'h0, f[16:13]});
    check("reply parity", 32'h0, {31'h0, ^f[17:2]});
  endtask : expect_reply

  task automatic wait_sys(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : wait_sys

  ////////////////////////////////////////////////////////////////////////////
  // Entry: a wrong key is ignored, the real key gets register two back.
  task automatic t_entry();
    do_reset(32'h0);
    check("mode after reset", 32'h0, {31'h0, cfg_mode_out});
    check("monitor enable", 32'h0, {31'h0, analog_monitor_output_enable_out});
    host_u.send(16'h5a5b, 16);
    wait_sys(100);
    check("mode on wrong key", 32'h0, {31'h0, cfg_mode_out});
    host_u.send(KEY_VALUE, 16);
    expect_reply(ADDR_CFG_TWO, 8'h00, SV_OK);
    check("mode entered", 32'h1, {31'h0, cfg_mode_out});
  endtask : t_entry

  // Writes echo, reads ignore the data field, fixed bytes are readable.
  task automatic t_rw();
    do_cmd(1'b0, ADDR_USER, 8'ha5, 1'b0);
    expect_reply(ADDR_USER, 8'ha5, SV_OK);
    check("user reg", 32'ha5, {24'h0, working_regs_out[7:0]});
    do_cmd(1'b1, ADDR_USER, 8'h5a, 1'b0);
    expect_reply(ADDR_USER, 8'ha5, SV_OK);
    do_cmd(1'b0, 4'h2, 8'h20, 1'b0);
    expect_reply(4'h2, 8'h20, SV_OK);
    do_cmd(1'b0, ADDR_CFG_TWO, 8'h20, 1'b0);
    expect_reply(ADDR_CFG_TWO, 8'h20, SV_OK);
    check("monitor enable", 32'h1, {31'h0, analog_monitor_output_enable_out});
    do_cmd(1'b1, 4'h5, 8'hff, 1'b0);
    expect_reply(4'h5, 8'h00, SV_OK);
    for (int i = 0; i < 4; i++) begin
      do_cmd(1'b1, ADDR_SERIAL + 4'(i), 8'h00, 1'b0);
      expect_reply(ADDR_SERIAL + 4'(i), SN[8*i +: 8], SV_OK);
    end
    do_cmd(1'b1, ADDR_MFG, 8'h00, 1'b0);
    expect_reply(ADDR_MFG, MFG, SV_OK);
  endtask : t_rw

  // A key inside the mode is ignored; a bad-parity write is refused.
  task automatic t_parity();
    host_u.send(KEY_VALUE, 16);
    do_cmd(1'b0, ADDR_USER, 8'h3c, 1'b1);
    expect_reply(4'h0, 8'h00, SV_ERR);
    check("user after error", 32'ha5, {24'h0, working_regs_out[7:0]});
  endtask : t_parity

  // Exit restarts without reset; a late key becomes a sync pulse.
  task automatic t_exit();
    int r0;
    int s0;
    r0 = restart_cnt;
    do_cmd(1'b0, ADDR_EXIT, EXIT_VALUE, 1'b0);
    expect_reply(ADDR_EXIT, 8'h00, SV_OK);
    wait_sys(10);
    check("restart pulses", 32'(r0 + 1), 32'(restart_cnt));
    check("mode left", 32'h0, {31'h0, cfg_mode_out});
    check("user kept", 32'ha5, {24'h0, working_regs_out[7:0]});
    wait_sys(INIT_SIM + 100);
    s0 = sync_cnt;
    host_u.send(KEY_VALUE, 16);
    wait_sys(100);
    check("late key mode", 32'h0, {31'h0, cfg_mode_out});
    check("sync pulses", 32'(s0 + 1), 32'(sync_cnt));
  endtask : t_exit

  // Locked fuses load at reset and turn writes into reads.
  task automatic t_locked();
    do_reset(FUSE);
    check("loaded regs", FUSE, working_regs_out);
    check("mode after reset", 32'h0, {31'h0, cfg_mode_out});
    host_u.send(KEY_VALUE, 16);
    expect_reply(ADDR_CFG_TWO, 8'h80, SV_OK);
    do_cmd(1'b0, ADDR_USER, 8'h55, 1'b0);
    expect_reply(ADDR_USER, 8'h11, SV_OK);
    do_cmd(1'b1, 4'h1, 8'h00, 1'b0);
    expect_reply(4'h1, 8'h33, SV_OK);
    check("locked regs", FUSE, working_regs_out);
  endtask : t_locked

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and a watchdog well beyond its expected length.
  initial begin
    rst_in = 1'b1;
    fuse_image_in = 32'h0;
    serial_number_in = SN;
    t_entry();
    t_rw();
    t_parity();
    t_exit();
    t_locked();
    close_out();
  end
  initial begin
    #600000;
    err_count++;
    close_out();
  end
endmodule : tb_sensor_config_mode_port
`default_nettype wire
